// ---- rtl/ssq_pkg.sv ----
// Constants and types shared by the stand-alone EEPROM sequencer
package ssq_pkg;
	// ----------------------------------------------------------------
	// EEPROM layout
	// ----------------------------------------------------------------
	localparam int CFG_PAIRS = 38;
	localparam logic [9:0] CFG_LAST = 10'(2 * CFG_PAIRS - 1);
	localparam logic [15:0] SEC_BASE = 16'h004D;
	localparam logic [7:0] FIFO_CODE = 8'h95;
	localparam logic [7:0] EMPTY_BYTE = 8'hFF;
	localparam int WR_BIT = 7;
	localparam logic [7:0] EE_READ_CMD = 8'h03;
	localparam logic [7:0] DUMMY_BYTE = 8'h00;
	localparam int MAX_FRAME = 64;
	localparam logic [7:0] MAX_FRAME_B = 8'h40;
	localparam logic [7:0] MAX_REPEAT = 8'hFE;
	localparam logic [3:0] LOWBAT_SLOT = 4'hE;
	localparam logic [3:0] NO_SLOT = 4'hF;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam logic [7:0] SPI_HALF = 8'h04;
	localparam logic [16:0] STRAP_WAIT = 17'h00003;
	localparam int DEB_SHIFT_DEF = 9;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_OPEN = 3'h1,
		ST_CFG = 3'h3,
		ST_SLEEP = 3'h2,
		ST_DEB = 3'h6,
		ST_SEC = 3'h7,
		ST_SEND = 3'h5,
		ST_DONE = 3'h4
	} ssq_state_t;

	typedef enum logic [2:0] {
		PH_OP = 3'h0,
		PH_RDATA = 3'h1,
		PH_REP = 3'h3,
		PH_LEN = 3'h2,
		PH_PAY = 3'h6
	} ssq_sec_ph_t;

	typedef struct packed {
		logic strap;
		logic [3:0] btn;
		logic rc;
		logic lowbat;
	} ssq_pins_t;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} ssq_reg_wr_t;
endpackage

// ---- rtl/ssq_spi_byte.sv ----
// SPI master byte engine, mode 0, MSB first
`timescale 1ns/1ps
module ssq_spi_byte #(
	parameter logic [7:0] HALF = ssq_pkg::SPI_HALF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Byte request
	input wire logic start,
	input wire logic [7:0] tx,
	output logic done,
	output logic [7:0] rx,
	// SPI pins
	input wire logic miso,
	output logic sck,
	output logic mosi
);
	typedef struct packed {
		logic m1;
		logic m2;
		logic busy;
		logic sck;
		logic [7:0] cnt;
		logic [2:0] bits;
		logic [7:0] sh;
		logic [7:0] rx;
		logic done;
	} ssq_spi_t;

	ssq_spi_t q;
	ssq_spi_t n;

	always_comb begin
		n = q;
		n.m1 = miso;
		n.m2 = q.m1;
		n.done = 1'b0;
		if (!q.busy) begin
			if (start) begin
				n.busy = 1'b1;
				n.sh = tx;
				n.cnt = 8'h00;
				n.bits = 3'h0;
				n.sck = 1'b0;
			end
		end else if (q.cnt == HALF - 8'h01) begin
			n.cnt = 8'h00;
			if (!q.sck) begin
				// Sample on the rising edge; sync lag is shorter than a half period
				n.sck = 1'b1;
				n.rx = {q.rx[6:0], q.m2};
			end else begin
				n.sck = 1'b0;
				n.sh = {q.sh[6:0], 1'b0};
				n.bits = q.bits + 3'h1;
				if (q.bits == 3'h7) begin
					n.busy = 1'b0;
					n.done = 1'b1;
				end
			end
		end else begin
			n.cnt = q.cnt + 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign done = q.done;
	assign rx = q.rx;
	assign sck = q.sck;
	assign mosi = q.sh[7];
endmodule

// ---- rtl/ssq_sequencer.sv ----
// Stand-alone sequencer: EEPROM configuration load, button wake and payload send
`timescale 1ns/1ps
// How it works
// - Strap high at reset: become SPI master under this state machine.
// - After power-up read the configuration region, apply it, then sleep.
// - In sleep any button edge wakes the block and starts the RC oscillator.
// - Debounce counts RC edges; button value taken after the programmed delay.
// - Settled value 1 to 15 selects a section; its writes override power-up ones.
// - Payload sent repeat-byte times, at most 254.
// - After the frame, synthesizer-lock goes low and the block sleeps again.
// - First 76 bytes are address/value pairs, at most 38 settings.
// - Section start derives from slot index and 6-bit section size.
// - Frames up to 64 bytes; addressing covers an 8 kbit EEPROM.
// - Section order: code 0x95, repeat, length, payload bytes.
// - Register writes inside a section are applied before the payload.
// - 3-bit debounce select sets the delay; zero bypasses debouncing.
// - Button patterns map to slots 0 to 14; none maps to no slot.
// - Bytes with bit 7 set, except 0xFF and, inside a section, the section code 0x95, are register writes to address minus 0x80.
// - Low battery seen in a normal frame sends slot 14 once afterwards.
module ssq_sequencer #(
	parameter int DEB_SHIFT = ssq_pkg::DEB_SHIFT_DEF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Pins
	input wire logic standalone_strap,
	input wire logic [3:0] button_inputs,
	input wire logic rc_clk,
	input wire logic low_battery,
	// Configuration
	input wire logic [5:0] section_size,
	input wire logic [2:0] debounce_select,
	input wire logic eol_enable,
	// SPI master to EEPROM
	output logic spi_sck,
	output logic spi_mosi,
	output logic spi_cs_b,
	input wire logic spi_miso,
	// Register writes
	output logic reg_wr_valid,
	output ssq_pkg::ssq_reg_wr_t reg_wr,
	// Payload stream
	output logic pay_valid,
	output logic [7:0] pay_data,
	output logic pay_last,
	input wire logic pay_ready,
	// Status
	output logic synth_lock,
	output logic rc_osc_en,
	output logic sleeping,
	output logic standalone_active
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		ssq_pkg::ssq_state_t st;
		ssq_pkg::ssq_sec_ph_t ph;
		ssq_pkg::ssq_pins_t sy1;
		ssq_pkg::ssq_pins_t sy2;
		logic parked;
		logic [3:0] btn_prev;
		logic rc_prev;
		logic [16:0] deb_cnt;
		logic in_sec;
		logic [1:0] hdr;
		logic [15:0] start_addr;
		logic [9:0] idx;
		logic [7:0] pend;
		logic [3:0] slot;
		logic [7:0] rep;
		logic [6:0] len;
		logic [6:0] wptr;
		logic [6:0] rptr;
		logic eol_pend;
		logic eol_frame;
		logic spi_start;
		logic [7:0] spi_tx;
		logic cs_b;
		logic wr_valid;
		ssq_pkg::ssq_reg_wr_t wr;
		logic pay_valid;
		logic pay_last;
		logic [7:0] pay_data;
		logic lock;
		logic rc_en;
		logic sleeping;
		logic active;
	} ssq_core_t;

	ssq_core_t q;
	ssq_core_t n;
	ssq_pkg::ssq_pins_t pins;
	logic spi_done;
	logic [7:0] spi_rx;
	logic [7:0] pay_mem [ssq_pkg::MAX_FRAME];
	logic mem_we;
	logic [5:0] mem_waddr;

	assign pins = {standalone_strap, button_inputs, rc_clk, low_battery};

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] slot_of(input logic [3:0] b);
		case (b)
			4'h1: slot_of = 4'h0;
			4'h2: slot_of = 4'h1;
			4'h4: slot_of = 4'h2;
			4'h8: slot_of = 4'h3;
			4'h3: slot_of = 4'h4;
			4'h5: slot_of = 4'h5;
			4'h6: slot_of = 4'h6;
			4'h9: slot_of = 4'h7;
			4'hA: slot_of = 4'h8;
			4'hC: slot_of = 4'h9;
			4'h7: slot_of = 4'hA;
			4'hB: slot_of = 4'hB;
			4'hD: slot_of = 4'hC;
			4'hE: slot_of = 4'hD;
			4'hF: slot_of = ssq_pkg::LOWBAT_SLOT;
			default: slot_of = ssq_pkg::NO_SLOT;
		endcase
	endfunction

	// Section size in bytes: 15 slots of 63 bytes still fit in 1 kbyte
	function automatic logic [15:0] sec_addr(input logic [3:0] s, input logic [5:0] sz);
		sec_addr = ssq_pkg::SEC_BASE + 16'(s) * 16'(sz);
	endfunction

	function automatic logic [16:0] deb_ticks(input logic [2:0] sel);
		deb_ticks = 17'(1) << (DEB_SHIFT + int'(sel) - 1);
	endfunction

	function automatic logic is_write(input logic [7:0] b);
		is_write = b[ssq_pkg::WR_BIT] && (b != ssq_pkg::EMPTY_BYTE);
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic fetch;
		logic [7:0] b;
		logic changed;
		fetch = 1'b0;
		b = spi_rx;
		n = q;
		mem_we = 1'b0;
		mem_waddr = q.wptr[5:0];
		n.sy1 = pins;
		n.sy2 = q.sy1;
		n.btn_prev = q.sy2.btn;
		n.rc_prev = q.sy2.rc;
		changed = (q.sy2.btn != q.btn_prev);
		n.spi_start = 1'b0;
		n.wr_valid = 1'b0;
		case (q.st)
			ssq_pkg::ST_OFF: begin
				if (q.deb_cnt < ssq_pkg::STRAP_WAIT) begin
					n.deb_cnt = q.deb_cnt + 17'h00001;
				end else if (!q.parked) begin
					n.parked = 1'b1;
					if (q.sy2.strap) begin
						n.active = 1'b1;
						n.in_sec = 1'b0;
						n.start_addr = 16'h0000;
						n.st = ssq_pkg::ST_OPEN;
						n.hdr = 2'h0;
					end
				end
			end
			ssq_pkg::ST_OPEN: begin
				// Read command, address high, address low, then the streaming read
				if (q.hdr == 2'h0) begin
					n.cs_b = 1'b0;
					n.spi_start = 1'b1;
					n.spi_tx = ssq_pkg::EE_READ_CMD;
					n.hdr = 2'h1;
				end else if (spi_done) begin
					n.spi_start = 1'b1;
					n.hdr = q.hdr + 2'h1;
					case (q.hdr)
						2'h1: n.spi_tx = q.start_addr[15:8];
						2'h2: n.spi_tx = q.start_addr[7:0];
						default: begin
							n.spi_tx = ssq_pkg::DUMMY_BYTE;
							n.idx = 10'h000;
							n.ph = ssq_pkg::PH_OP;
							n.st = q.in_sec ? ssq_pkg::ST_SEC : ssq_pkg::ST_CFG;
						end
					endcase
				end
			end
			ssq_pkg::ST_CFG: begin
				if (spi_done) begin
					if (!q.idx[0]) begin
						n.pend = b;
					end else if (is_write(q.pend)) begin
						n.wr_valid = 1'b1;
						n.wr = {q.pend[6:0], b};
					end
					if (q.idx == ssq_pkg::CFG_LAST) begin
						n.cs_b = 1'b1;
						n.st = ssq_pkg::ST_SLEEP;
					end else begin
						n.idx = q.idx + 10'h001;
						fetch = 1'b1;
					end
				end
			end
			ssq_pkg::ST_SLEEP: begin
				n.sleeping = 1'b1;
				n.rc_en = 1'b0;
				if (changed) begin
					n.st = ssq_pkg::ST_DEB;
					n.deb_cnt = 17'h00000;
					n.rc_en = 1'b1;
					n.sleeping = 1'b0;
				end
			end
			ssq_pkg::ST_DEB: begin
				// Any change restarts the wait so bounce never reaches the decode unless debounce_select is zero
				if (changed) begin
					n.deb_cnt = 17'h00000;
				end else if (q.sy2.rc && !q.rc_prev) begin
					n.deb_cnt = q.deb_cnt + 17'h00001;
				end
				if (!changed && (debounce_select == 3'h0 || q.deb_cnt >= deb_ticks(debounce_select))) begin
					n.slot = slot_of(q.sy2.btn);
					if (slot_of(q.sy2.btn) == ssq_pkg::NO_SLOT) begin
						n.st = ssq_pkg::ST_SLEEP;
						n.rc_en = 1'b0;
						n.sleeping = 1'b1;
					end else begin
						n.in_sec = 1'b1;
						n.start_addr = sec_addr(slot_of(q.sy2.btn), section_size);
						n.eol_frame = 1'b0;
						n.eol_pend = 1'b0;
						n.st = ssq_pkg::ST_OPEN;
						n.hdr = 2'h0;
					end
				end
			end
			ssq_pkg::ST_SEC: begin
				if (spi_done) begin
					fetch = 1'b1;
					case (q.ph)
						ssq_pkg::PH_OP: begin
							if (b == ssq_pkg::FIFO_CODE) begin
								n.ph = ssq_pkg::PH_REP;
							end else if (is_write(b)) begin
								n.pend = b;
								n.ph = ssq_pkg::PH_RDATA;
							end else begin
								fetch = 1'b0;
								n.cs_b = 1'b1;
								n.st = ssq_pkg::ST_DONE;
							end
						end
						ssq_pkg::PH_RDATA: begin
							n.wr_valid = 1'b1;
							n.wr = {q.pend[6:0], b};
							n.ph = ssq_pkg::PH_OP;
						end
						ssq_pkg::PH_REP: begin
							// Zero repeat still sends once; the extra frame is always single
							if (q.eol_frame || b == 8'h00) begin
								n.rep = 8'h01;
							end else begin
								n.rep = (b > ssq_pkg::MAX_REPEAT) ? ssq_pkg::MAX_REPEAT : b;
							end
							n.ph = ssq_pkg::PH_LEN;
						end
						ssq_pkg::PH_LEN: begin
							n.len = (b > ssq_pkg::MAX_FRAME_B) ? 7'(ssq_pkg::MAX_FRAME_B) : b[6:0];
							n.wptr = 7'h00;
							n.ph = ssq_pkg::PH_PAY;
							if (b == 8'h00) begin
								fetch = 1'b0;
								n.cs_b = 1'b1;
								n.st = ssq_pkg::ST_DONE;
							end
						end
						default: begin
							mem_we = 1'b1;
							n.wptr = q.wptr + 7'h01;
							if (q.wptr == q.len - 7'h01) begin
								fetch = 1'b0;
								n.cs_b = 1'b1;
								n.rptr = 7'h00;
								n.lock = 1'b1;
								n.st = ssq_pkg::ST_SEND;
							end
						end
					endcase
				end
			end
			ssq_pkg::ST_SEND: begin
				if (q.sy2.lowbat && eol_enable && !q.eol_frame && q.slot != ssq_pkg::LOWBAT_SLOT) begin
					n.eol_pend = 1'b1;
				end
				// One idle cycle between bytes keeps the memory read registered
				if (!q.pay_valid) begin
					n.pay_valid = 1'b1;
					n.pay_data = pay_mem[q.rptr[5:0]];
					n.pay_last = (q.rptr == q.len - 7'h01);
				end else if (pay_ready) begin
					n.pay_valid = 1'b0;
					if (q.pay_last) begin
						n.rptr = 7'h00;
						n.rep = q.rep - 8'h01;
						if (q.rep == 8'h01) begin
							n.st = ssq_pkg::ST_DONE;
						end
					end else begin
						n.rptr = q.rptr + 7'h01;
					end
				end
			end
			ssq_pkg::ST_DONE: begin
				n.cs_b = 1'b1;
				if (q.eol_pend) begin
					n.eol_pend = 1'b0;
					n.eol_frame = 1'b1;
					n.slot = ssq_pkg::LOWBAT_SLOT;
					n.start_addr = sec_addr(ssq_pkg::LOWBAT_SLOT, section_size);
					n.st = ssq_pkg::ST_OPEN;
					n.hdr = 2'h0;
				end else begin
					n.lock = 1'b0;
					n.rc_en = 1'b0;
					n.sleeping = 1'b1;
					n.st = ssq_pkg::ST_SLEEP;
				end
			end
			default: begin
				n.st = ssq_pkg::ST_OFF;
			end
		endcase
		if (fetch) begin
			n.spi_start = 1'b1;
			n.spi_tx = ssq_pkg::DUMMY_BYTE;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.cs_b <= 1'b1;
		end else begin
			q <= n;
		end
	end

	always_ff @(posedge mclk) begin
		if (mem_we) begin
			pay_mem[mem_waddr] <= spi_rx;
		end
	end

	// ----------------------------------------------------------------
	// SPI engine
	// ----------------------------------------------------------------
	ssq_spi_byte u_spi (
		.mclk(mclk),
		.rst_b(rst_b),
		.start(q.spi_start),
		.tx(q.spi_tx),
		.done(spi_done),
		.rx(spi_rx),
		.miso(spi_miso),
		.sck(spi_sck),
		.mosi(spi_mosi)
	);

	assign spi_cs_b = q.cs_b;
	assign reg_wr_valid = q.wr_valid;
	assign reg_wr = q.wr;
	assign pay_valid = q.pay_valid;
	assign pay_data = q.pay_data;
	assign pay_last = q.pay_last;
	assign synth_lock = q.lock;
	assign rc_osc_en = q.rc_en;
	assign sleeping = q.sleeping;
	assign standalone_active = q.active;
endmodule

// ---- dv/ssq_sequencer_sva.sv ----
// Port assertions for the stand-alone sequencer
`timescale 1ns/1ps
module ssq_sequencer_sva #(
	parameter int DEB_SHIFT = ssq_pkg::DEB_SHIFT_DEF
) (
	// Clock and reset
	input logic mclk,
	input logic rst_b,
	// Pins and configuration
	input logic standalone_strap,
	input logic [3:0] button_inputs,
	input logic rc_clk,
	input logic low_battery,
	input logic [5:0] section_size,
	input logic [2:0] debounce_select,
	input logic eol_enable,
	// SPI
	input logic spi_sck,
	input logic spi_mosi,
	input logic spi_cs_b,
	input logic spi_miso,
	// Register writes and payload
	input logic reg_wr_valid,
	input ssq_pkg::ssq_reg_wr_t reg_wr,
	input logic pay_valid,
	input logic [7:0] pay_data,
	input logic pay_last,
	input logic pay_ready,
	// Status
	input logic synth_lock,
	input logic rc_osc_en,
	input logic sleeping,
	input logic standalone_active
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// --------
	// Properties
	// --------
	property p_wake;
		sleeping && $changed(button_inputs) |-> ##[1:4] (rc_osc_en && !sleeping);
	endproperty
	a_wake: assert property (p_wake) else $error("no wake after button edge");
	property p_wr_gap;
		reg_wr_valid |=> !reg_wr_valid [*8];
	endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("register writes too close");
	property p_pay_hold;
		pay_valid && !pay_ready |=> pay_valid && $stable(pay_data) && $stable(pay_last);
	endproperty
	a_pay_hold: assert property (p_pay_hold) else $error("payload byte not held");
	property p_pay_bubble;
		pay_valid && pay_ready |=> !pay_valid;
	endproperty
	a_pay_bubble: assert property (p_pay_bubble) else $error("payload valid after accept");
	property p_sleep_idle;
		sleeping |-> !synth_lock && !rc_osc_en && spi_cs_b;
	endproperty
	a_sleep_idle: assert property (p_sleep_idle) else $error("blocks active in sleep");
	property p_lock_fall;
		$fell(synth_lock) |-> ##[0:8] sleeping;
	endproperty
	a_lock_fall: assert property (p_lock_fall) else $error("no sleep after frame");
	property p_off_idle;
		!standalone_active |-> spi_cs_b && !pay_valid && !reg_wr_valid && !synth_lock;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("activity without strap");
	property p_sck_half;
		$rose(spi_sck) |=> spi_sck [*3] ##1 !spi_sck;
	endproperty
	a_sck_half: assert property (p_sck_half) else $error("serial clock half period wrong");
	c_wake: cover property (sleeping && $changed(button_inputs));
	c_write: cover property (reg_wr_valid);
	c_last: cover property (pay_valid && pay_ready && pay_last);
endmodule

// ---- dv/ssq_eeprom_model.sv ----
// Behavioural SPI EEPROM answering sequential reads
`timescale 1ns/1ps
module ssq_eeprom_model (
	// SPI pins
	input logic sck,
	input logic cs_b,
	input logic mosi,
	output logic miso
);
	logic [7:0] mem [0:1023]; // 8 kbit array
	logic [7:0] sh = 8'h00;
	logic [7:0] cur = 8'h00;
	logic [15:0] addr = 16'h0000;
	int bits = 0;
	int ph = 0;
	initial miso = 1'b0;
	always @(posedge sck or posedge cs_b) begin
		if (cs_b) begin
			bits = 0;
			ph = 0;
		end else begin
			sh = {sh[6:0], mosi};
			bits = (bits + 1) % 8;
			if (bits == 0) begin
				if (ph == 1) addr[15:8] = sh;
				if (ph == 2) addr[7:0] = sh;
				if (ph == 3) addr = addr + 16'h0001;
				if (ph >= 2) cur = mem[addr[9:0]];
				if (ph < 3) ph = ph + 1;
			end
		end
	end
	// Deselected line shows the inverse of its last bit, never a held value
	always @(negedge sck or posedge cs_b) begin
		if (cs_b) miso <= ~miso;
		else if (ph == 3) miso <= cur[3'(7 - bits)];
	end
endmodule

// ---- dv/ssq_sequencer_bench.sv ----
// Self-checking bench for the stand-alone sequencer
`timescale 1ns/1ps
module ssq_sequencer_bench;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic standalone_strap = 1'b1;
	logic [3:0] button_inputs = 4'h0;
	logic rc_clk = 1'b0;
	logic low_battery = 1'b0;
	logic [5:0] section_size = 6'h10;
	logic [2:0] debounce_select = 3'h0;
	logic eol_enable = 1'b0;
	logic pay_ready = 1'b0;
	logic spi_sck, spi_mosi, spi_cs_b, spi_miso;
	logic reg_wr_valid, pay_valid, pay_last, synth_lock, rc_osc_en, sleeping, standalone_active;
	logic [7:0] pay_data;
	ssq_pkg::ssq_reg_wr_t reg_wr;
	int failures = 0;
	int compares = 0;
	int tick = 0;
	logic [8:0] pays [$];
	logic [14:0] wrs [$];
	// Pattern in the high nibble, slot it selects in the low nibble
	logic [7:0] rows [15] = '{8'h10, 8'h21, 8'h34, 8'h42, 8'h55, 8'h66, 8'h7A, 8'h83,
		8'h97, 8'hA8, 8'hBB, 8'hC9, 8'hDC, 8'hED, 8'hFE};
	logic [7:0] cfg [8] = '{8'h81, 8'h05, 8'h12, 8'h34, 8'h93, 8'h1C, 8'hA0, 8'h77};
	logic [7:0] s0 [8] = '{8'h97, 8'h00, 8'h95, 8'h02, 8'h03, 8'hA0, 8'h5A, 8'hC3};
	logic [8:0] ep [7] = '{9'h0A0, 9'h05A, 9'h1C3, 9'h0A0, 9'h05A, 9'h1C3, 9'h1AE};

	ssq_sequencer #(.DEB_SHIFT(1)) dut (.mclk(mclk), .rst_b(rst_b), .standalone_strap(standalone_strap),
		.button_inputs(button_inputs), .rc_clk(rc_clk), .low_battery(low_battery), .section_size(section_size),
		.debounce_select(debounce_select), .eol_enable(eol_enable), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
		.spi_cs_b(spi_cs_b), .spi_miso(spi_miso), .reg_wr_valid(reg_wr_valid), .reg_wr(reg_wr),
		.pay_valid(pay_valid), .pay_data(pay_data), .pay_last(pay_last), .pay_ready(pay_ready),
		.synth_lock(synth_lock), .rc_osc_en(rc_osc_en), .sleeping(sleeping), .standalone_active(standalone_active));
	ssq_eeprom_model u_ee (.sck(spi_sck), .cs_b(spi_cs_b), .mosi(spi_mosi), .miso(spi_miso));

	// --------
	// Clocks, stalls and capture
	// --------
	always #12.5 mclk = ~mclk;
	// RC oscillator runs only while enabled, off the mclk grid
	initial begin
		#7;
		forever #100 rc_clk = rc_osc_en ? ~rc_clk : 1'b0;
	end
	always @(posedge mclk) begin
		tick <= tick + 1;
		pay_ready <= (tick % 3) != 0;
		if (pay_valid && pay_ready) pays.push_back({pay_last, pay_data});
		if (reg_wr_valid) wrs.push_back(reg_wr);
	end
	// About 60k cycles, roughly three times the expected run
	initial begin
		#1500000;
		failures++;
		complete_run();
	end

	// --------
	// Tasks
	// --------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_for(input logic want, input int lim);
		int n;
		n = 0;
		while (sleeping !== want && n < lim) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(sleeping, want, "sleeping");
	endtask
	task automatic press(input logic [3:0] pat);
		pays.delete();
		wrs.delete();
		@(posedge mclk);
		button_inputs <= pat;
		wait_for(1'b0, 40);
		wait_for(1'b1, 30000);
	endtask
	task automatic release_all();
		@(posedge mclk);
		button_inputs <= 4'h0;
		wait_for(1'b0, 40);
		wait_for(1'b1, 3000);
	endtask
	task automatic complete_run();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// --------
	// Main sequence
	// --------
	initial begin
		int b;
		for (int a = 0; a < 1024; a++) u_ee.mem[a] = 8'hFF;
		// Non-default settings written as address plus 0x80, and one pair without bit 7 that is skipped
		for (int i = 0; i < 8; i++) u_ee.mem[i < 6 ? i : i + 68] = cfg[i];
		for (int s = 0; s < 15; s++) begin
			b = int'(ssq_pkg::SEC_BASE) + s * int'(section_size);
			u_ee.mem[b] = ssq_pkg::FIFO_CODE;
			u_ee.mem[b + 1] = 8'h01;
			u_ee.mem[b + 2] = 8'h01;
			u_ee.mem[b + 3] = {4'hA, 4'(s)};
		end
		for (int i = 0; i < 8; i++) u_ee.mem[int'(ssq_pkg::SEC_BASE) + i] = s0[i];
		repeat (16) @(posedge mclk);
		chk(spi_cs_b, 1'b1, "select in reset");
		rst_b <= 1'b1;
		wait_for(1'b1, 8000);
		chk(standalone_active, 1'b1, "standalone");
		chk(wrs.size(), 3, "config writes");
		chk(wrs[0], 15'h0105, "config write 0");
		chk(wrs[1], 15'h131C, "config write 1");
		chk(wrs[2], 15'h2077, "config write 2");
		for (int i = 0; i < 15; i++) begin
			press(rows[i][7:4]);
			chk(pays[0][7:0], {4'hA, rows[i][3:0]}, "slot byte");
			chk(synth_lock, 1'b0, "lock after frame");
			release_all();
		end
		low_battery <= 1'b1;
		eol_enable <= 1'b1;
		press(4'h1);
		chk(wrs.size(), 1, "section writes");
		chk(wrs[0], 15'h1700, "section write");
		chk(pays.size(), 7, "payload count");
		for (int i = 0; i < 7; i++) chk(pays[i], ep[i], "payload");
		low_battery <= 1'b0;
		eol_enable <= 1'b0;
		debounce_select <= 3'h3;
		release_all();
		pays.delete();
		@(posedge mclk);
		button_inputs <= 4'h1;
		repeat (10) @(posedge mclk);
		button_inputs <= 4'h3;
		wait_for(1'b1, 30000);
		chk(pays[0][7:0], 8'hA4, "debounced slot");
		release_all();
		// Awkward sections: bad first byte, zero length, zero repeat with an oversized length
		u_ee.mem[int'(ssq_pkg::SEC_BASE) + 16] = 8'h12;
		u_ee.mem[int'(ssq_pkg::SEC_BASE) + 34] = 8'h00;
		u_ee.mem[int'(ssq_pkg::SEC_BASE) + 49] = 8'h00;
		u_ee.mem[int'(ssq_pkg::SEC_BASE) + 50] = 8'h50;
		for (int i = 0; i < 80; i++) u_ee.mem[int'(ssq_pkg::SEC_BASE) + 51 + i] = 8'(i);
		press(4'h2);
		chk(pays.size(), 0, "bad opcode payload");
		release_all();
		press(4'h4);
		chk(pays.size(), 0, "zero length payload");
		release_all();
		press(4'h8);
		chk(pays.size(), 64, "clamped payload count");
		chk(pays[62], 9'h03E, "clamped payload byte");
		chk(pays[63], 9'h13F, "clamped payload last");
		release_all();
		rst_b <= 1'b0;
		standalone_strap <= 1'b0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (200) @(posedge mclk);
		chk(standalone_active, 1'b0, "strap low active");
		chk(spi_cs_b, 1'b1, "strap low select");
		complete_run();
	end
endmodule

bind ssq_sequencer ssq_sequencer_sva #(.DEB_SHIFT(DEB_SHIFT)) u_sva (.mclk(mclk), .rst_b(rst_b),
	.standalone_strap(standalone_strap), .button_inputs(button_inputs), .rc_clk(rc_clk),
	.low_battery(low_battery), .section_size(section_size), .debounce_select(debounce_select),
	.eol_enable(eol_enable), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_cs_b(spi_cs_b),
	.spi_miso(spi_miso), .reg_wr_valid(reg_wr_valid), .reg_wr(reg_wr), .pay_valid(pay_valid),
	.pay_data(pay_data), .pay_last(pay_last), .pay_ready(pay_ready), .synth_lock(synth_lock),
	.rc_osc_en(rc_osc_en), .sleeping(sleeping), .standalone_active(standalone_active));
